// ### counter_timebase_dup_count_sync_test.sv
// Self-checking bench for the two-counter timebase block
`timescale 1ns/10ps
`default_nettype none
module counter_timebase_dup_count_sync_test;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0][1:0] src_sel = '0;
  logic [1:0] arm = '0;
  ctb_pkg::ctb_pins_t [1:0] pin_in;
  ctb_pkg::ctb_meas_t [1:0] meas_out;
  logic [1:0] ctr_int_out;
  logic tb_mid_en;
  logic tb_slow_en;
  logic [31:0] c;
  logic t;
  int err_total = 0;
  int checks = 0;
  initial forever #50 core_clk = ~core_clk;
  ctb_pins_model PM (.core_clk(core_clk), .pins(pin_in));
  ctb_counter_top DUT (.core_clk(core_clk), .rst_n(rst_n), .pin_in(pin_in),
    .src_sel(src_sel), .arm(arm), .meas_out(meas_out), .ctr_int_out(ctr_int_out),
    .tb_mid_en(tb_mid_en), .tb_slow_en(tb_slow_en));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize;
    $display("Checks %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic meas(input int i, input int p, output logic [31:0] cnt);
    int n;
    n = 0;
    fork
      PM.gates(i, p, 1);
      while (meas_out[i].valid !== 1'b1)
      begin
        @(negedge core_clk);
        n++;
        if (n > 3000)
        begin
          err_total++;
          summarize();
        end
      end
    join
    cnt = meas_out[i].count;
  endtask
  task automatic t_ext;
    src_sel[0] = ctb_pkg::SRC_EXT;
    arm[0] = 1'b1;
    meas(0, 4, c);
    repeat (3) PM.src(0, 9);
    t = ctr_int_out[0];
    meas(0, 4, c);
    chk("ext count", 32'h3, c);
    chk("int out", {31'h0, ~t}, {31'h0, ctr_int_out[0]});
    @(negedge core_clk) chk("valid low", 32'h0, {31'h0, meas_out[0].valid});
    meas(0, 4, c);
    chk("no source", 32'h0, c);
    $display("t_ext done");
  endtask
  task automatic t_internal;
    int p[3] = '{40, 40, 1600};
    int d[3] = '{1, ctb_pkg::DIV_MID, ctb_pkg::DIV_MID * ctb_pkg::DIV_SLOW};
    for (int k = 0; k < 3; k++)
    begin
      arm[1] = 1'b0;
      src_sel[1] = 2'(k + 1);
      @(negedge core_clk) arm[1] = 1'b1;
      meas(1, p[k], c);
      repeat (2)
      begin
        t = ctr_int_out[1];
        meas(1, p[k], c);
        chk("timebase count", 32'(p[k] / d[k]), c);
        chk("int out 1", {31'h0, ~t}, {31'h0, ctr_int_out[1]});
      end
    end
    $display("t_internal done");
  endtask
  initial
  begin
    repeat (12) @(negedge core_clk);
    rst_n = 1'b1;
    chk("reset valid", 32'h0, {30'h0, meas_out[1].valid, meas_out[0].valid});
    t_ext();
    t_internal();
    summarize();
  end
endmodule
`default_nettype wire

// ### ctb_asserts.sv
// Concurrent checks on the counter timebase block ports
`timescale 1ns/10ps
`default_nettype none
module ctb_asserts #(
  parameter int CW = ctb_pkg::CNT_W,
  parameter int NC = ctb_pkg::NUM_CTR
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Watched ports
  input wire ctb_pkg::ctb_pins_t [NC-1:0] pin_in,
  input wire logic [NC-1:0][1:0] src_sel,
  input wire logic [NC-1:0] arm,
  input wire ctb_pkg::ctb_meas_t [NC-1:0] meas_out,
  input wire logic [NC-1:0] ctr_int_out,
  input wire logic tb_mid_en,
  input wire logic tb_slow_en
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire v0 = meas_out[0].valid;
  logic [9:0] sc_ff;
  // Zero until the first slow enable, so the reset phase is not judged
  always_ff @(posedge core_clk)
  begin
    if (!rst_n) sc_ff <= 10'h000;
    else if (tb_slow_en) sc_ff <= 10'h001;
    else if (sc_ff != 10'h000) sc_ff <= sc_ff + 10'h001;
  end
  a_mid_every_four: assert property (tb_mid_en |=> !tb_mid_en [*3] ##1 tb_mid_en)
    else $error("mid enable not every fourth cycle");
  a_slow_on_mid: assert property (tb_slow_en |-> tb_mid_en)
    else $error("slow enable off the mid enable");
  a_slow_gap: assert property (tb_slow_en && sc_ff != 10'h000 |-> sc_ff == 10'h320)
    else $error("slow enable spacing wrong");
  a_valid_pulse: assert property (v0 |=> !v0)
    else $error("valid longer than one cycle");
  a_int_toggle: assert property (v0 |-> ctr_int_out[0] != $past(ctr_int_out[0]))
    else $error("internal output did not toggle");
  a_gate_store: assert property (arm[0] && $past(arm[0]) && $rose(pin_in[0].gate)
    |-> ##[2:5] v0)
    else $error("gate edge not stored");
  a_idle_quiet: assert property (!arm[0] && !$past(arm[0]) && !$past(arm[0], 2) |-> !v0)
    else $error("store while idle");
  a_count_hold: assert property (!v0 && arm[0] && $past(arm[0])
    |-> $stable(meas_out[0].count))
    else $error("count changed without store");
  c_zero_store: cover property (v0 && meas_out[0].count == 32'h0000_0000);
  c_store_one: cover property (meas_out[1].valid);
  c_slow: cover property (tb_slow_en);
endmodule
bind ctb_counter_top ctb_asserts #(.CW(CW), .NC(NC)) CHK (.core_clk(core_clk), .rst_n(rst_n),
  .pin_in(pin_in), .src_sel(src_sel), .arm(arm), .meas_out(meas_out),
  .ctr_int_out(ctr_int_out), .tb_mid_en(tb_mid_en), .tb_slow_en(tb_slow_en));
`default_nettype wire

// ### ctb_counter_top.sv
// Two buffered-period counters with timebase-synchronous duplicate count prevention
// Overview of operation
// RL1: Source and Gate pins are resampled on the 80 MHz timebase before edge detection.
// RL2: A rising Gate edge stores the count even when no Source edge came since the last one.
// RL3: The counter steps once per Source pulse however long the pulse stays high.
// RL4: Count and internal output update on the 80 MHz timebase only.
// RL5: Duplicate count prevention is always on and cannot be disabled.
// RL6: The source-synchronous path that loses counts when Source stops is never built.
// RL7: 80 MHz, 20 MHz and 100 kHz timebases are selectable Source inputs per 32-bit counter.
// RL8: The 20 MHz timebase is an integer division of the 80 MHz timebase.
// RL9: The 100 kHz timebase is the 20 MHz timebase divided by 200.
// RL10: The count of Source pulses between consecutive rising Gate edges is stored.
// RL11: The 80 MHz to 20 MHz divider uses a ratio of four.
`timescale 1ns/10ps
`default_nettype none
module ctb_counter_top #(
  parameter int CW = ctb_pkg::CNT_W,
  parameter int NC = ctb_pkg::NUM_CTR
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Measured system pins, asynchronous
  input wire ctb_pkg::ctb_pins_t [NC-1:0] pin_in,
  // Per counter configuration
  input wire logic [NC-1:0][1:0] src_sel,
  input wire logic [NC-1:0] arm,
  // Measurements
  output ctb_pkg::ctb_meas_t [NC-1:0] meas_out,
  output logic [NC-1:0] ctr_int_out,
  output logic tb_mid_en,
  output logic tb_slow_en
);
  typedef struct packed {
    ctb_pkg::ctb_state_t state;
    logic [1:0] src_sync;
    logic [1:0] gate_sync;
    logic src_prev;
    logic gate_prev;
    logic [CW-1:0] count;
    ctb_pkg::ctb_meas_t meas;
    logic int_out;
  } ctb_ctr_t;

  // Source edge select shared by every counter
  function automatic logic src_tick(input logic [1:0] sel, input logic ext_edge,
                                    input logic mid, input logic slow);
    case (sel)
      ctb_pkg::SRC_EXT: src_tick = ext_edge;
      ctb_pkg::SRC_TB_FAST: src_tick = 1'b1;
      ctb_pkg::SRC_TB_MID: src_tick = mid;
      ctb_pkg::SRC_TB_SLOW: src_tick = slow;
      default: src_tick = 1'b0;
    endcase
  endfunction

  logic mid_en;
  logic slow_en;

  ctb_timebase u_tb (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .tb_mid_en(mid_en),
    .tb_slow_en(slow_en)
  );

  assign tb_mid_en = mid_en;
  assign tb_slow_en = slow_en;

  genvar gi;
  generate
    for (gi = 0; gi < NC; gi++)
    begin : g_ctr
      ctb_ctr_t st_ff;
      ctb_ctr_t nxt_st;
      logic src_rise;
      logic gate_rise;
      logic tick;

      // RL1: edges seen only after second stage
      assign src_rise = st_ff.src_sync[1] & ~st_ff.src_prev;
      assign gate_rise = st_ff.gate_sync[1] & ~st_ff.gate_prev;
      // RL7: timebase selection
      assign tick = src_tick(src_sel[gi], src_rise, mid_en, slow_en);

      always_comb
      begin
        nxt_st = st_ff;
        // RL1: two-stage resampling
        nxt_st.src_sync = {st_ff.src_sync[0], pin_in[gi].src};
        nxt_st.gate_sync = {st_ff.gate_sync[0], pin_in[gi].gate};
        nxt_st.src_prev = st_ff.src_sync[1];
        nxt_st.gate_prev = st_ff.gate_sync[1];
        nxt_st.meas.valid = 1'b0;
        case (st_ff.state)
          ctb_pkg::CTB_IDLE:
          begin
            nxt_st.count = ctb_pkg::CNT_RESET;
            nxt_st.int_out = 1'b0;
            if (arm[gi])
              nxt_st.state = ctb_pkg::CTB_RUN;
          end
          ctb_pkg::CTB_RUN:
          begin
            // RL2: gate stores without a source edge
            if (gate_rise)
            begin
              // RL10: pulses between gate edges
              nxt_st.meas.valid = 1'b1;
              nxt_st.meas.count = st_ff.count;
              // A tick in the gate cycle opens the next period, so none is lost
              nxt_st.count = tick ? CW'(1) : ctb_pkg::CNT_RESET;
              nxt_st.int_out = ~st_ff.int_out;
            end
            // RL3: one step per edge
            else if (tick)
            begin
              nxt_st.count = st_ff.count + CW'(1);
            end
            if (!arm[gi])
              nxt_st.state = ctb_pkg::CTB_IDLE;
          end
          default: nxt_st.state = ctb_pkg::CTB_IDLE;
        endcase
      end

      // RL4: all updates on the timebase clock
      // RL5: no bypass path exists
      // RL6: source-clocked path omitted
      always_ff @(posedge core_clk)
      begin
        if (!rst_n)
        begin
          st_ff <= '0;
          st_ff.state <= ctb_pkg::CTB_IDLE;
        end
        else
        begin
          st_ff <= nxt_st;
        end
      end

      assign meas_out[gi] = st_ff.meas;
      assign ctr_int_out[gi] = st_ff.int_out;
    end
  endgenerate
endmodule
`default_nettype wire

// ### ctb_pins_model.sv
// Measured-system model driving Source and Gate pins at the falling edge
`timescale 1ns/10ps
`default_nettype none
module ctb_pins_model (
  // Clock
  input wire logic core_clk,
  // Pins
  output var ctb_pkg::ctb_pins_t [1:0] pins
);
  initial pins = '0;
  // ORDER: Source held high hi clocks then low two
  task automatic src(input int i, input int hi);
    @(negedge core_clk) pins[i].src = 1'b1;
    repeat (hi) @(negedge core_clk);
    pins[i].src = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask
  // ORDER: Gate rises exactly p clocks apart, each level two clocks at least
  task automatic gates(input int i, input int p, input int n);
    repeat (n)
    begin
      @(negedge core_clk) pins[i].gate = 1'b1;
      repeat (p / 2 - 1) @(negedge core_clk);
      @(negedge core_clk) pins[i].gate = 1'b0;
      repeat (p - p / 2 - 1) @(negedge core_clk);
    end
  endtask
endmodule
`default_nettype wire

// ### ctb_pkg.sv
// Shared constants and carrier types for the counter timebase block
package ctb_pkg;
  localparam int CNT_W = 32;
  localparam int TB_FAST_HZ = 80000000;
  localparam int TB_MID_HZ = 20000000;
  localparam int TB_SLOW_HZ = 100000;
  localparam int DIV_MID = TB_FAST_HZ / TB_MID_HZ;
  localparam int DIV_SLOW = TB_MID_HZ / TB_SLOW_HZ;
  localparam int NUM_CTR = 2;
  localparam logic [1:0] SRC_EXT = 2'h0;
  localparam logic [1:0] SRC_TB_FAST = 2'h1;
  localparam logic [1:0] SRC_TB_MID = 2'h2;
  localparam logic [1:0] SRC_TB_SLOW = 2'h3;
  localparam logic [CNT_W-1:0] CNT_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    CTB_IDLE,
    CTB_RUN
  } ctb_state_t;

  typedef struct packed {
    logic valid;
    logic [CNT_W-1:0] count;
  } ctb_meas_t;

  typedef struct packed {
    logic src;
    logic gate;
  } ctb_pins_t;
endpackage

// ### ctb_timebase.sv
// Timebase dividers: 20 MHz and 100 kHz enables from the 80 MHz clock
`timescale 1ns/10ps
`default_nettype none
module ctb_timebase #(
  parameter int MID_RATIO = ctb_pkg::DIV_MID,
  parameter int SLOW_RATIO = ctb_pkg::DIV_SLOW
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Enables
  output logic tb_mid_en,
  output logic tb_slow_en
);
  typedef struct packed {
    logic [7:0] mid_cnt;
    logic [7:0] slow_cnt;
    logic mid;
    logic slow;
  } ctb_div_t;

  ctb_div_t st_ff;
  ctb_div_t nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.mid = 1'b0;
    nxt_st.slow = 1'b0;
    // RL11: divide by four
    // RL8: integer divide
    if (st_ff.mid_cnt == 8'(MID_RATIO - 1))
    begin
      nxt_st.mid_cnt = 8'h00;
      nxt_st.mid = 1'b1;
      // RL9: divide by 200
      if (st_ff.slow_cnt == 8'(SLOW_RATIO - 1))
      begin
        nxt_st.slow_cnt = 8'h00;
        nxt_st.slow = 1'b1;
      end
      else
      begin
        nxt_st.slow_cnt = st_ff.slow_cnt + 8'h01;
      end
    end
    else
    begin
      nxt_st.mid_cnt = st_ff.mid_cnt + 8'h01;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign tb_mid_en = st_ff.mid;
  assign tb_slow_en = st_ff.slow;
endmodule
`default_nettype wire
